// >>> rtl/sprite_plane_defs.svh
// offsets, field positions and counts of the sprite plane fetch and format block
//
// Contract
// RULE1: colour standard bit picks conversion coefficients, 0 standard-definition, 1 high-definition; ignored for RGB.
// RULE2: byte order field unpacks a 4:2:2 word in one of four byte arrangements.
// RULE3: byte order field is ignored unless the source is packed 4:2:2.
// RULE4: rotation bit set turns the plane half a revolution; clear leaves it unrotated.
// RULE5: software points the offset at the lower right corner when rotating.
// RULE6: pacing bit clear requests whenever buffer has room; set requests in bursts.
// RULE7: layout bit clear means linear surface, set means X-tiled surface.
// RULE8: tiled layout takes tile pitch from line pitch and reinterprets base and start.
// RULE9: destination key shows sprite where primary pixel matches key, else primary unchanged.
// RULE10: software never enables destination and source keying together.
// RULE11: first pixel address is surface base plus the linear byte offset.
// RULE12: software aligns the offset to a pixel, or pixel pair for 4:2:2.
// RULE13: under rotation software sets offset to the last pixel of the last line.
// RULE14: linear offset is ignored whenever tiled layout is selected.
// RULE15: written offset waits and takes effect at vertical blank or with pipe off.
// RULE16: destination compare uses key value; a zero mask bit ignores that bit.
// RULE17: source format code zero means packed 4:2:2 with separate byte order.
// RULE18: rotation fetches from the lower right corner with decreasing addresses.
`ifndef SPRITE_PLANE_DEFS_SVH
`define SPRITE_PLANE_DEFS_SVH

// ****************************************
// register map
// ****************************************
`define CTRL_ADDR      20'h73180
`define PAN_ADDR       20'h73184
`define STAT_ADDR      20'h731a0
`define CTRL_RESET     32'h00000000
`define PAN_RESET      32'h00000000
`define CTRL_WMASK     32'h0c5fc404

// ****************************************
// control fields
// ****************************************
`define FMT_HI         27
`define FMT_LO         26
`define SRC_KEY_BIT    22
`define CONV_OFF_BIT   19
`define STD_BIT        18
`define ORDER_HI       17
`define ORDER_LO       16
`define ROT_BIT        15
`define PACE_BIT       14
`define TILED_BIT      10
`define DKEY_BIT       2
`define FMT_YUV422     2'h0
`define FMT_BGRX       2'h2

// ****************************************
// fetch and tiling counts
// ****************************************
`define BURST_WORDS    8'h10
`define TILE_ROW_BYTES 32'h00000200
`define TILE_BYTES     32'h00001000
`define TILE_LINES     32'h00000008

`endif

// >>> rtl/sprite_plane_pkg.sv
// types shared by the sprite plane fetch and format block
package sprite_plane_pkg;

   typedef enum logic [1:0] {
      F_IDLE  = 2'h0,
      F_RUN   = 2'h1,
      F_BURST = 2'h3
   } fetch_state_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [19:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [1:0]  hit;
      logic [23:0] p1;
      logic [23:0] p0;
   } pix_pair_t;

   typedef struct packed {
      logic [31:0]  ctrl;
      logic [31:0]  off_pend;
      logic [31:0]  off_act;
      logic         pend;
      logic [31:0]  rdata;
      fetch_state_t fst;
      logic [11:0]  xw;
      logic [11:0]  y;
      logic [7:0]   burst_left;
      logic         req;
      logic [31:0]  req_addr;
      logic         out_valid;
      logic [1:0]   out_n;
      pix_pair_t    out;
   } sprite_state_t;

endpackage : sprite_plane_pkg

// >>> rtl/pixel_unpack.sv
// unpacks one source word into a pixel pair and converts 4:2:2 to rgb
`timescale 1ns/1ps
`default_nettype none
`include "sprite_plane_defs.svh"
module pixel_unpack (
   input  wire logic [31:0] word,
   input  wire logic [31:0] ctrl,
   output logic      [23:0] px0,
   output logic      [23:0] px1,
   output logic      [1:0]  n_pix
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [7:0] clamp8(input logic signed [19:0] v);
      if (v < 20'sd0) begin
         return 8'h00;
      end
      if (v > 20'sd255) begin
         return 8'hff;
      end
      return v[7:0];
   endfunction : clamp8

   // coefficients in 1/256 steps
   function automatic logic [23:0] to_rgb(input logic [7:0] y, input logic [7:0] u,
                                          input logic [7:0] v, input logic hd);
      logic signed [19:0] ys;
      logic signed [19:0] us;
      logic signed [19:0] vs;
      logic signed [19:0] kr;
      logic signed [19:0] kgu;
      logic signed [19:0] kgv;
      logic signed [19:0] kb;
      ys  = $signed({12'h000, y}) * 20'sd256;
      us  = $signed({12'h000, u}) - 20'sd128;
      vs  = $signed({12'h000, v}) - 20'sd128;
      kr  = hd ? 20'sd403 : 20'sd359;
      kgu = hd ? 20'sd48  : 20'sd88;
      kgv = hd ? 20'sd120 : 20'sd183;
      kb  = hd ? 20'sd475 : 20'sd454;
      return {clamp8((ys + kr * vs) >>> 8),
              clamp8((ys - kgu * us - kgv * vs) >>> 8),
              clamp8((ys + kb * us) >>> 8)};
   endfunction : to_rgb

   // ****************************************
   // unpack and convert
   // ****************************************
   always_comb begin
      logic [7:0] y1;
      logic [7:0] y2;
      logic [7:0] u;
      logic [7:0] v;
      y1 = word[7:0];
      y2 = word[23:16];
      u  = word[15:8];
      v  = word[31:24];
      case (ctrl[`ORDER_HI:`ORDER_LO]) // see RULE2
         2'h0: begin y1 = word[7:0];   u = word[15:8]; y2 = word[23:16]; v = word[31:24]; end
         2'h1: begin u  = word[7:0];   y1 = word[15:8]; v = word[23:16]; y2 = word[31:24]; end
         2'h2: begin y1 = word[7:0];   v = word[15:8]; y2 = word[23:16]; u = word[31:24]; end
         default: begin v = word[7:0]; y1 = word[15:8]; u = word[23:16]; y2 = word[31:24]; end
      endcase
      px0   = word[23:0];
      px1   = 24'h000000;
      n_pix = 2'h1;
      // byte order only matters for code zero; rgb passes untouched
      if (ctrl[`FMT_HI:`FMT_LO] == `FMT_YUV422) begin // see RULE3 see RULE17
         n_pix = 2'h2;
         if (ctrl[`CONV_OFF_BIT]) begin
            px0 = {v, y1, u};
            px1 = {v, y2, u};
         end else begin
            px0 = to_rgb(y1, u, v, ctrl[`STD_BIT]); // see RULE1
            px1 = to_rgb(y2, u, v, ctrl[`STD_BIT]);
         end
      end
   end

endmodule : pixel_unpack
`default_nettype wire

// >>> rtl/sprite_plane_fetch_format.sv
// sprite plane control, fetch address generation and pixel formatting
`timescale 1ns/1ps
`default_nettype none
`include "sprite_plane_defs.svh"
module sprite_plane_fetch_format (
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   input  wire sprite_plane_pkg::reg_req_t  reg_req,
   output logic                      [31:0] reg_rdata,
   input  wire logic                        vblank_start,
   input  wire logic                        pipe_enable,
   input  wire logic                        line_start,
   input  wire logic                 [31:0] surface_base,
   input  wire logic                 [14:0] line_pitch,
   input  wire logic                 [11:0] line_words,
   input  wire logic                 [11:0] frame_lines,
   input  wire logic                 [23:0] key_compare_value,
   input  wire logic                 [23:0] key_compare_mask,
   input  wire logic                 [7:0]  buffer_space,
   output logic                             fetch_req,
   output logic                      [31:0] fetch_addr,
   input  wire logic                        pix_valid,
   input  wire logic                 [31:0] pix_word,
   input  wire logic                 [47:0] primary_pair,
   output logic                             out_valid,
   output logic                      [1:0]  out_count,
   output sprite_plane_pkg::pix_pair_t      out_pair
);

   sprite_plane_pkg::sprite_state_t s_q;
   sprite_plane_pkg::sprite_state_t s_d;

   logic [23:0] px0;
   logic [23:0] px1;
   logic [1:0]  n_pix;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic key_hit(input logic [23:0] prim, input logic [23:0] kv,
                                    input logic [23:0] km);
      return ((prim ^ kv) & km) == 24'h000000; // see RULE16
   endfunction : key_hit

   // byte address of word x on line y, linear or X-tiled
   function automatic logic [31:0] word_addr(input logic [31:0] ctrl, input logic [31:0] base,
                                             input logic [31:0] off, input logic [14:0] pitch,
                                             input logic [11:0] xw, input logic [11:0] y,
                                             input logic [11:0] nw, input logic [11:0] nl);
      logic [31:0] xb;
      logic [31:0] yl;
      logic [31:0] lin;
      xb  = {18'h0, xw, 2'h0};
      yl  = {20'h0, y} * {17'h0, pitch};
      lin = ctrl[`ROT_BIT] ? (base + off - yl - xb) : (base + off + yl + xb); // see RULE11 see RULE18
      if (ctrl[`TILED_BIT]) begin // see RULE7 see RULE14
         // tiled ignores the pan offset; rotation mirrors the coordinates instead
         if (ctrl[`ROT_BIT]) begin
            xb = {18'h0, nw - 12'h001 - xw, 2'h0};
            yl = {20'h00000, nl - 12'h001 - y};
         end else begin
            yl = {20'h00000, y};
         end
         // tile row pitch comes from the line pitch register
         return base + (yl / `TILE_LINES) * {17'h0, pitch} * `TILE_LINES // see RULE8
                + (xb / `TILE_ROW_BYTES) * `TILE_BYTES
                + (yl % `TILE_LINES) * `TILE_ROW_BYTES + (xb % `TILE_ROW_BYTES);
      end
      return lin;
   endfunction : word_addr

   // ****************************************
   // pixel conversion
   // ****************************************
   pixel_unpack u_unpack (
      .word  (pix_word),
      .ctrl  (s_q.ctrl),
      .px0   (px0),
      .px1   (px1),
      .n_pix (n_pix)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [23:0] a;
      logic [23:0] b;
      logic        last;
      logic        grant;
      s_d = s_q;
      a = px0;
      b = px1;
      last  = s_q.xw == line_words - 12'h001;
      grant = 1'b0;
      s_d.req = 1'b0;
      s_d.out_valid = 1'b0;

      // register port
      if (reg_req.wr && reg_req.addr == `CTRL_ADDR) begin
         s_d.ctrl = reg_req.wdata & `CTRL_WMASK;
      end
      if (reg_req.wr && reg_req.addr == `PAN_ADDR) begin
         s_d.off_pend = reg_req.wdata;
         s_d.pend = 1'b1;
      end
      if (reg_req.rd) begin
         case (reg_req.addr)
            `CTRL_ADDR: s_d.rdata = s_q.ctrl;
            `PAN_ADDR:  s_d.rdata = s_q.off_pend;
            `STAT_ADDR: s_d.rdata = {29'h0, s_q.fst == sprite_plane_pkg::F_BURST,
                                     s_q.fst != sprite_plane_pkg::F_IDLE, s_q.pend};
            default:    s_d.rdata = 32'h00000000;
         endcase
      end

      // pending offset lands at blank, or at once with the pipe off
      if (vblank_start || !pipe_enable) begin // see RULE15
         s_d.off_act = s_d.off_pend;
         s_d.pend = 1'b0;
      end
      if (vblank_start) begin
         s_d.y = 12'h000;
      end

      // fetch pacing
      case (s_q.fst)
         sprite_plane_pkg::F_IDLE: begin
            if (line_start && pipe_enable) begin
               s_d.xw = 12'h000;
               s_d.fst = sprite_plane_pkg::F_RUN;
            end
         end
         sprite_plane_pkg::F_RUN: begin
            if (!s_q.ctrl[`PACE_BIT]) begin
               grant = buffer_space != 8'h00; // see RULE6
            end else if (buffer_space >= `BURST_WORDS) begin
               s_d.fst = sprite_plane_pkg::F_BURST; // see RULE6
               s_d.burst_left = `BURST_WORDS;
            end
         end
         sprite_plane_pkg::F_BURST: begin
            grant = 1'b1;
            s_d.burst_left = s_q.burst_left - 8'h01;
            if (s_q.burst_left == 8'h01) begin
               s_d.fst = sprite_plane_pkg::F_RUN;
            end
         end
         default: s_d.fst = sprite_plane_pkg::F_IDLE;
      endcase
      if (grant) begin
         s_d.req = 1'b1;
         s_d.req_addr = word_addr(s_q.ctrl, surface_base, s_q.off_act, line_pitch,
                                  s_q.xw, s_q.y, line_words, frame_lines);
         s_d.xw = s_q.xw + 12'h001;
         if (last) begin
            s_d.fst = sprite_plane_pkg::F_IDLE;
            s_d.y = s_q.y + 12'h001;
         end
      end
      if (!pipe_enable) begin
         s_d.fst = sprite_plane_pkg::F_IDLE;
      end

      // pixel path: words arrive in fetch order, so rotation swaps the pair
      if (pix_valid) begin
         if (s_q.ctrl[`ROT_BIT] && n_pix == 2'h2) begin // see RULE4
            a = px1;
            b = px0;
         end
         s_d.out_valid = 1'b1;
         s_d.out_n = n_pix;
         s_d.out.hit = 2'h3;
         s_d.out.p0 = a;
         s_d.out.p1 = b;
         if (s_q.ctrl[`DKEY_BIT]) begin // see RULE9
            s_d.out.hit[0] = key_hit(primary_pair[23:0], key_compare_value, key_compare_mask);
            s_d.out.hit[1] = key_hit(primary_pair[47:24], key_compare_value, key_compare_mask);
            s_d.out.p0 = s_d.out.hit[0] ? a : primary_pair[23:0];
            s_d.out.p1 = s_d.out.hit[1] ? b : primary_pair[47:24];
         end
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
         s_q.ctrl <= `CTRL_RESET;
         s_q.off_pend <= `PAN_RESET;
         s_q.off_act <= `PAN_RESET;
         s_q.fst <= sprite_plane_pkg::F_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata  = s_q.rdata;
   assign fetch_req  = s_q.req;
   assign fetch_addr = s_q.req_addr;
   assign out_valid  = s_q.out_valid;
   assign out_count  = s_q.out_n;
   assign out_pair   = s_q.out;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   rgb_ignores_std_a: assert property ( // see RULE1
      pix_valid && s_q.ctrl[`FMT_HI:`FMT_LO] == `FMT_BGRX && !s_q.ctrl[`DKEY_BIT]
      |=> out_pair.p0 == $past(pix_word[23:0]) && out_count == 2'h1)
      else $error("rgb pixel altered by format path");

   order_zero_a: assert property ( // see RULE2
      pix_valid && s_q.ctrl[`FMT_HI:`FMT_LO] == `FMT_YUV422 && s_q.ctrl[`CONV_OFF_BIT]
      && s_q.ctrl[`ORDER_HI:`ORDER_LO] == 2'h0 && !s_q.ctrl[`ROT_BIT] && !s_q.ctrl[`DKEY_BIT]
      |=> out_pair.p0 == {$past(pix_word[31:24]), $past(pix_word[7:0]), $past(pix_word[15:8])})
      else $error("byte order zero unpacked wrongly");

   rotate_swap_a: assert property ( // see RULE4
      pix_valid && s_q.ctrl[`FMT_HI:`FMT_LO] == `FMT_YUV422 && s_q.ctrl[`CONV_OFF_BIT]
      && s_q.ctrl[`ORDER_HI:`ORDER_LO] == 2'h0 && s_q.ctrl[`ROT_BIT] && !s_q.ctrl[`DKEY_BIT]
      |=> out_pair.p0[15:8] == $past(pix_word[23:16]))
      else $error("rotated pair not swapped");

   trickle_room_a: assert property ( // see RULE6
      s_q.fst == sprite_plane_pkg::F_RUN && !s_q.ctrl[`PACE_BIT] && pipe_enable
      && buffer_space == 8'h00 |=> !fetch_req)
      else $error("request issued with no buffer room");

   burst_run_a: assert property ( // see RULE6
      s_q.fst == sprite_plane_pkg::F_RUN && s_q.ctrl[`PACE_BIT] && pipe_enable
      && buffer_space >= `BURST_WORDS && s_q.xw == 12'h000 && line_words > 12'h002
      && !vblank_start && !reg_req.wr ##1 pipe_enable [*2]
      |=> fetch_req [*2])
      else $error("burst did not issue back to back");

   first_addr_a: assert property ( // see RULE11 see RULE14
      s_q.fst == sprite_plane_pkg::F_RUN && s_q.xw == 12'h000 && s_q.y == 12'h000
      && !s_q.ctrl[`PACE_BIT] && buffer_space != 8'h00 && pipe_enable
      && !(s_q.ctrl[`TILED_BIT] && s_q.ctrl[`ROT_BIT])
      |=> fetch_addr == $past(surface_base) + ($past(s_q.ctrl[`TILED_BIT]) ? 32'h0
                                               : $past(s_q.off_act)))
      else $error("first pixel address wrong");

   offset_apply_a: assert property ( // see RULE15
      vblank_start && !reg_req.wr |=> s_q.off_act == $past(s_q.off_pend) && !s_q.pend)
      else $error("pending offset not applied at blank");

   offset_hold_a: assert property ( // see RULE15
      !vblank_start && pipe_enable |=> s_q.off_act == $past(s_q.off_act))
      else $error("active offset moved outside blank");

   key_pass_a: assert property ( // see RULE9 see RULE16
      pix_valid && s_q.ctrl[`DKEY_BIT]
      && !key_hit(primary_pair[23:0], key_compare_value, key_compare_mask)
      |=> out_pair.p0 == $past(primary_pair[23:0]) && !out_pair.hit[0])
      else $error("primary pixel not passed on key miss");

   rot_descend_a: assert property ( // see RULE18
      fetch_req && s_q.ctrl[`ROT_BIT] && !s_q.ctrl[`TILED_BIT] && s_q.xw != 12'h000
      && !s_q.ctrl[`PACE_BIT] && s_q.fst == sprite_plane_pkg::F_RUN && buffer_space != 8'h00
      && !reg_req.wr && pipe_enable && !vblank_start
      |=> fetch_req && fetch_addr == $past(fetch_addr) - 32'h4)
      else $error("rotated fetch not descending");

endmodule : sprite_plane_fetch_format
`default_nettype wire

// >>> verif/mem_side.sv
// memory side model: answers each word request with address-derived data
`timescale 1ns/1ps
`default_nettype none
module mem_side (
   input  wire logic        clk,
   input  wire logic        fetch_req,
   input  wire logic [31:0] fetch_addr,
   input  wire logic [31:0] salt,
   input  wire logic        slow,
   output logic             pix_valid,
   output logic      [31:0] pix_word
);
   logic [31:0] q[$];
   bit          ph;
   initial begin
      pix_valid = 1'b0;
      pix_word  = 32'h00000000;
   end
   always @(posedge clk) begin
      if (fetch_req) begin
         q.push_back(fetch_addr);
      end
   end
   // slow mode answers every other cycle; idle data is scrambled, never held
   always @(negedge clk) begin
      ph = ~ph;
      if (q.size() > 0 && (!slow || ph)) begin
         pix_valid <= 1'b1;
         pix_word  <= q.pop_front() ^ salt;
      end else begin
         pix_valid <= 1'b0;
         pix_word  <= ~pix_word;
      end
   end
endmodule : mem_side
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the sprite plane fetch and format block
`timescale 1ns/1ps
`default_nettype none
`include "sprite_plane_defs.svh"
module tb;
   logic                        clk = 1'b0, reset_n = 1'b0, pv = 1'b0, slow = 1'b0;
   logic                        vblank_start = 1'b0, pipe_enable = 1'b0, line_start = 1'b0;
   logic                        fetch_req, pix_valid, out_valid;
   sprite_plane_pkg::reg_req_t  reg_req = '0;
   sprite_plane_pkg::pix_pair_t out_pair, e;
   logic [31:0]                 reg_rdata, fetch_addr, pix_word, word_s, d;
   logic [31:0]                 base = '0, salt = '0, ctrl = '0, off = '0;
   logic [14:0]                 pitch = 15'h0400;
   logic [11:0]                 lw = 12'h004;
   logic [23:0]                 kv = '0, km = '0;
   logic [7:0]                  space = '0;
   logic [47:0]                 prim = '0, prim_s;
   logic [1:0]                  out_count;
   int                          mismatches = 0, checks = 0, cyc = 0;
   int                          nx = 0, ly = 0, run = 0, maxrun = 0;
   wire logic                   yuv = ctrl[`FMT_HI:`FMT_LO] == `FMT_YUV422;

   sprite_plane_fetch_format u_sprite_plane_fetch_format (.clk(clk), .reset_n(reset_n),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .vblank_start(vblank_start),
      .pipe_enable(pipe_enable), .line_start(line_start), .surface_base(base),
      .line_pitch(pitch), .line_words(lw), .frame_lines(12'h002), .key_compare_value(kv),
      .key_compare_mask(km), .buffer_space(space), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .pix_valid(pix_valid), .pix_word(pix_word),
      .primary_pair(prim), .out_valid(out_valid), .out_count(out_count), .out_pair(out_pair));
   mem_side u_mem_side (.clk(clk), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
      .salt(salt), .slow(slow), .pix_valid(pix_valid), .pix_word(pix_word));

   always #20 clk = ~clk;

   // ****************************************
   // reference model
   // ****************************************
   function automatic logic [31:0] eaddr(int x, int y);
      int xb = 4 * x;
      if (ctrl[`TILED_BIT]) begin
         return base + (y / 8) * pitch * 8 + (xb / 512) * 4096 + (y % 8) * 512 + xb % 512;
      end
      if (ctrl[`ROT_BIT]) begin
         return base + off - y * pitch - xb;
      end
      return base + off + y * pitch + xb;
   endfunction : eaddr
   function automatic int cl(int a);
      return a < 0 ? 0 : (a > 255 ? 255 : a);
   endfunction : cl
   function automatic logic [23:0] cv(logic [7:0] y, logic [7:0] u, logic [7:0] v);
      int c[4];
      int uu = int'(u) - 128;
      int vv = int'(v) - 128;
      int yy = int'(y);
      if (ctrl[`CONV_OFF_BIT]) begin
         return {v, y, u};
      end
      if (ctrl[`STD_BIT]) begin
         c = '{403, 48, 120, 475};
      end else begin
         c = '{359, 88, 183, 454};
      end
      return {8'(cl(yy + c[0] * vv / 256)), 8'(cl(yy - (c[1] * uu + c[2] * vv) / 256)),
              8'(cl(yy + c[3] * uu / 256))};
   endfunction : cv
   function automatic sprite_plane_pkg::pix_pair_t pm(logic [31:0] w, logic [47:0] pr);
      logic [7:0]                  y1, y2, u, v;
      sprite_plane_pkg::pix_pair_t r;
      case (ctrl[`ORDER_HI:`ORDER_LO])
         2'h0: {v, y2, u, y1} = w;
         2'h1: {y2, v, y1, u} = w;
         2'h2: {u, y2, v, y1} = w;
         default: {y2, u, y1, v} = w;
      endcase
      r.hit = 2'h3;
      r.p0 = ctrl[`ROT_BIT] ? cv(y2, u, v) : cv(y1, u, v);
      r.p1 = ctrl[`ROT_BIT] ? cv(y1, u, v) : cv(y2, u, v);
      if (!yuv) begin
         r.p0 = w[23:0];
      end
      if (ctrl[`DKEY_BIT]) begin
         r.hit = {((pr[47:24] ^ kv) & km) == 24'h0, ((pr[23:0] ^ kv) & km) == 24'h0};
         r.p0 = r.hit[0] ? r.p0 : pr[23:0];
         r.p1 = r.hit[1] ? r.p1 : pr[47:24];
      end
      return r;
   endfunction : pm
   // coefficient rounding is not pinned down, so allow two steps per channel
   function automatic logic [23:0] snap(logic [23:0] x, logic [23:0] g);
      for (int k = 0; k < 24; k += 8) begin
         int df = int'(g[k+:8]) - int'(x[k+:8]);
         if (df >= -2 && df <= 2) x[k+:8] = g[k+:8];
      end
      return x;
   endfunction : snap

   // ****************************************
   // checks and drivers
   // ****************************************
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s at %0t got %h exp %h", what, $time, got, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   task automatic wr(input logic [19:0] a, input logic [31:0] v);
      @(negedge clk);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(negedge clk);
      reg_req = '0;
   endtask : wr
   task automatic rd(input logic [19:0] a, output logic [31:0] v);
      @(negedge clk);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(negedge clk);
      reg_req = '0;
      v = reg_rdata;
   endtask : rd
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse
   task automatic line(input int y);
      nx = 0;
      ly = y;
      pulse(line_start);
      for (int i = 0; i < 300 && nx < lw; i++) @(negedge clk);
      repeat (12) @(negedge clk);
      chk(nx, lw, "words");
   endtask : line

   always @(posedge clk) begin
      pv <= pix_valid;
      word_s <= pix_word;
      prim_s <= prim;
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         test_done();
      end
   end
   always @(negedge clk) begin
      prim <= 48'({$urandom, $urandom});
      if (fetch_req) begin
         chk(fetch_addr, eaddr(nx, ly), "addr");
         nx++;
         run++;
      end else begin
         run = 0;
      end
      if (run > maxrun) maxrun = run;
      if (out_valid !== pv) chk(out_valid, pv, "valid");
      if (pv) begin
         e = pm(word_s, prim_s);
         if (!yuv) begin
            e.p1 = out_pair.p1;
            e.hit[1] = out_pair.hit[1];
         end else if (!ctrl[`CONV_OFF_BIT]) begin
            e.p0 = snap(e.p0, out_pair.p0);
            e.p1 = snap(e.p1, out_pair.p1);
         end
         chk(out_pair, e, "pixels");
         chk(out_count, yuv ? 2'h2 : 2'h1, "count");
      end
   end

   initial begin
      void'($urandom(68));
      repeat (4) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      rd(`PAN_ADDR, d);
      chk(d, `PAN_RESET, "pan reset");
      wr(`CTRL_ADDR, 32'hffffffff);
      rd(`CTRL_ADDR, d);
      chk(d, `CTRL_WMASK, "ctrl mask");
      wr(`CTRL_ADDR, 32'h08000000);
      ctrl = 32'h08000000;
      wr(20'h73190, 32'hffffffff);
      rd(20'h73190, d);
      chk(d, 32'h0, "unmapped");
      $display("register test done");
      pipe_enable = 1'b1;
      space = 8'hff;
      base = $urandom & 32'hfffffffc;
      off = 32'h00000040;
      wr(`PAN_ADDR, off);
      pulse(vblank_start);
      wr(`PAN_ADDR, 32'h00000080);
      rd(`PAN_ADDR, d);
      chk(d, 32'h00000080, "pan pending");
      rd(`STAT_ADDR, d);
      chk(d[0], 1'b1, "pend set");
      line(0);
      @(negedge clk);
      pipe_enable = 1'b0;
      @(negedge clk);
      pipe_enable = 1'b1;
      off = 32'h00000080;
      rd(`STAT_ADDR, d);
      chk(d[0], 1'b0, "pend clear");
      line(1);
      $display("offset test done");
      for (int i = 0; i < 256; i++) begin
         // source key never set together with dest key
         ctrl = {4'h0, i[0] ? 2'h2 : 2'h0, 6'h0, i[5], i[4], i[2:1], i[3], 4'h0,
                 i[7] & ~i[3], 7'h0, i[6], 2'h0};
         slow = 1'($urandom);
         salt = $urandom;
         kv = 24'($urandom);
         km = 24'h000001 << ($urandom % 24);
         off = ctrl[`ROT_BIT] ? pitch + 4 * (lw - 1) : $urandom & 32'hfffffffc;
         wr(`CTRL_ADDR, ctrl);
         wr(`PAN_ADDR, off);
         pulse(vblank_start);
         line(0);
         line(1);
      end
      $display("format test done");
      lw = 12'h014;
      for (int p = 0; p < 2; p++) begin
         ctrl = {4'h0, 2'h2, 11'h0, 1'(p), 14'h0};
         wr(`CTRL_ADDR, ctrl);
         pulse(vblank_start);
         space = p ? 8'h0f : 8'h00;
         nx = 0;
         ly = 0;
         maxrun = 0;
         pulse(line_start);
         repeat (10) @(negedge clk);
         chk(nx, 0, "held");
         space = p ? 8'h10 : 8'h01;
         for (int k = 0; k < 200 && nx < lw; k++) @(negedge clk);
         repeat (8) @(negedge clk);
         chk(nx, lw, "words");
         chk(maxrun, p ? 16 : 20, "run");
      end
      $display("pacing test done");
      test_done();
   end
endmodule : tb
`default_nettype wire
